// ### evc_top.sv
// Purpose: bank of eighteen cascadable event counters
// Assumes: apb master, event lines on the core clock
// Notes:   one wait state on every apb access
//
// Chosen here: the register offsets and the APB interface to the registers.
`include "evc_consts.svh"
module evc_top (
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [`ADDR_W-1:0]           paddr_i,
    input  wire evc_pkg::word_t               pwdata_i,
    input  wire evc_pkg::ev_t [`NUM_CNT-1:0]  event_lines_i,
    output logic                              pready_o,
    output evc_pkg::word_t                    prdata_o,
    output logic                              pslverr_o,
    output logic                              performance_monitor_interrupt_o
);
    import evc_pkg::*;

    // ************************************************
    // declarations
    // ************************************************

    word_t                  ctrl_r [`NUM_CNT];
    logic [`NUM_CNT-1:0]    ovf_r;
    logic [`NUM_CNT-1:0]    ord_run_r;
    logic [`NUM_CNT-1:0]    ext_run_r;
    logic                   pmi_r;
    bus_state_t             bus_state_r;
    logic                   pready_r;
    logic                   pslverr_r;
    word_t                  prdata_r;

    count_t                 count [`NUM_CNT];
    logic [`NUM_CNT-1:0]    wrap;
    logic [`NUM_CNT-1:0]    run;
    logic [`NUM_CNT-1:0]    casc;
    logic [`NUM_CNT-1:0]    ext;
    logic [`NUM_CNT-1:0]    ord_start;
    logic [`NUM_CNT-1:0]    ord_hold;
    logic [`NUM_CNT-1:0]    ext_start;
    logic [`NUM_CNT-1:0]    ext_hold;
    logic [`NUM_CNT-1:0]    wr_ctrl;
    logic [`NUM_CNT-1:0]    wr_lo;
    logic [`NUM_CNT-1:0]    wr_hi;
    logic [`NUM_CNT-1:0]    pmi_src;

    logic [4:0]             sel_idx;
    logic [1:0]             sel_reg;
    logic                   hit;
    logic                   wr_go;
    word_t                  rd_word;

    // ************************************************
    // helper functions
    // ************************************************

    // bits that software may store in a control word
    function automatic word_t ctrl_mask(input int i);
        word_t m;
        m = '0;
        m[`CTRL_EN_BIT]    = 1'b1;
        m[`CTRL_FORCE_BIT] = 1'b1;
        m[`CTRL_PMI_BIT]   = 1'b1;
        m[`CTRL_CASC_BIT]  = 1'b1;
        if (i < `FIRST_NOSEL) begin
            m[`CTRL_SEL_LSB +: `SEL_W] = {`SEL_W{1'b1}};
        end
        // extended bit exists on local 0, 3, 4 and 5 only
        if (i == 12 || i == 15 || i == 16 || i == 17) begin
            m[`CTRL_EXT_BIT] = 1'b1;
        end
        return m;
    endfunction

    // ************************************************
    // address decode
    // ************************************************

    // slot index in bits 8:4, word in slot in bits 3:2
    assign sel_idx = paddr_i[8:4];
    assign sel_reg = paddr_i[3:2];
    assign hit     = paddr_i[1:0] == 2'h0
                     && paddr_i[`ADDR_W-1:9] == 3'h0
                     && sel_idx < `NUM_CNT
                     && sel_reg != 2'h3;

    // writes land only on the edge that completes the access
    assign wr_go = psel_i && penable_i && pready_r && pwrite_i && hit;

    // per-counter write strobes
    always_comb begin
        wr_ctrl = '0;
        wr_lo   = '0;
        wr_hi   = '0;
        if (wr_go) begin
            wr_ctrl[sel_idx] = sel_reg == `REG_CTRL;
            wr_lo[sel_idx]   = sel_reg == `REG_LO;
            wr_hi[sel_idx]   = sel_reg == `REG_HI;
        end
    end

    // read mux; the counter keeps running underneath
    always_comb begin
        rd_word = '0;
        if (hit) begin
            case (sel_reg)
                `REG_CTRL: begin
                    rd_word = ctrl_r[sel_idx];
                    rd_word[`CTRL_OVF_BIT] = ovf_r[sel_idx];
                end
                `REG_LO: begin
                    rd_word = count[sel_idx][31:0];
                end
                `REG_HI: begin
                    rd_word[`CNT_W-33:0] = count[sel_idx][`CNT_W-1:32];
                end
                default: begin
                    rd_word = '0;
                end
            endcase
        end
    end

    // ************************************************
    // apb answer machine
    // ************************************************

    // data is captured one edge ahead so outputs come from flops
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus_state_r <= BUS_IDLE;
            pready_r    <= 1'b0;
            pslverr_r   <= 1'b0;
            prdata_r    <= '0;
        end else begin
            case (bus_state_r)
                BUS_IDLE: begin
                    if (psel_i && penable_i) begin
                        bus_state_r <= BUS_ANSWER;
                        pready_r    <= 1'b1;
                        pslverr_r   <= !hit;
                        prdata_r    <= pwrite_i ? '0 : rd_word;
                    end
                end
                BUS_ANSWER: begin
                    bus_state_r <= BUS_IDLE;
                    pready_r    <= 1'b0;
                    pslverr_r   <= 1'b0;
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                    pready_r    <= 1'b0;
                end
            endcase
        end
    end

    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;
    assign prdata_o  = prdata_r;

    // ************************************************
    // control words
    // ************************************************

    // unwritable bits stay zero, so reserved bits read zero
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 18; i++) begin
            if (rst_i) begin
                ctrl_r[i] <= `CTRL_RST;
            end else if (wr_ctrl[i]) begin
                ctrl_r[i] <= pwdata_i & ctrl_mask(i);
            end
        end
    end

    // ************************************************
    // counters
    // ************************************************

    // eighteen slots: blocks of 4, 4, 4 and 6
    for (genvar i = 0; i < 18; i++) begin : g_cnt
        ev_t inc;
        // counters without an event select always see their lines
        if (i < `FIRST_NOSEL) begin : g_sel
            assign inc = ctrl_r[i][`CTRL_SEL_LSB +: `SEL_W] == 3'h0
                         ? 4'h0 : event_lines_i[i];
        end else begin : g_nosel
            assign inc = event_lines_i[i];
        end

        assign casc[i] = ctrl_r[i][`CTRL_CASC_BIT];
        assign ext[i]  = ctrl_r[i][`CTRL_EXT_BIT];
        // enable, or a live cascade start, lets it count
        assign run[i]  = ctrl_r[i][`CTRL_EN_BIT]
                         || ord_run_r[i] || ext_run_r[i];
        assign pmi_src[i] = ovf_r[i] && ctrl_r[i][`CTRL_PMI_BIT];

        evc_counter u_cnt (
            .sys_clk_i (sys_clk_i),
            .rst_i     (rst_i),
            .run_i     (run[i]),
            .inc_i     (inc),
            .force_i   (ctrl_r[i][`CTRL_FORCE_BIT]),
            .wr_lo_i   (wr_lo[i]),
            .wr_hi_i   (wr_hi[i]),
            .wdata_i   (pwdata_i),
            .count_o   (count[i]),
            .wrap_o    (wrap[i])
        );
    end

    // ************************************************
    // cascade routing
    // ************************************************

    evc_cascade_route u_route (
        .wrap_i      (wrap),
        .ovf_i       (ovf_r),
        .casc_i      (casc),
        .ext_i       (ext),
        .ord_start_o (ord_start),
        .ord_hold_o  (ord_hold),
        .ext_start_o (ext_start),
        .ext_hold_o  (ext_hold)
    );

    // cascade run lasts while own flag and source overflow stay set;
    // a start in the same cycle as a clear wins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ord_run_r <= '0;
            ext_run_r <= '0;
        end else begin
            ord_run_r <= ord_start | (ord_run_r & ord_hold);
            ext_run_r <= ext_start | (ext_run_r & ext_hold);
        end
    end

    // ************************************************
    // overflow flags and interrupt
    // ************************************************

    // sticky; writing 0 clears, a wrap in that cycle wins
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 18; i++) begin
            if (rst_i) begin
                ovf_r[i] <= 1'b0;
            end else if (wrap[i]) begin
                ovf_r[i] <= 1'b1;
            end else if (wr_ctrl[i]) begin
                ovf_r[i] <= ovf_r[i] & pwdata_i[`CTRL_OVF_BIT];
            end
        end
    end

    // level request while any enabled overflow stays set
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pmi_r <= 1'b0;
        end else begin
            pmi_r <= |pmi_src;
        end
    end

    assign performance_monitor_interrupt_o = pmi_r;

    // ************************************************
    // assertions
    // ************************************************

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_access_wait;
        psel_i && penable_i && !pready_r && bus_state_r == BUS_IDLE;
    endsequence

    sequence s_answer_pulse;
        pready_r ##1 !pready_r;
    endsequence

    property p_bus_answer;
        s_access_wait |=> s_answer_pulse;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("apb answer not given after one wait");

    property p_ovf_set;
        wrap[0] |=> ovf_r[0];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set on wrap");

    property p_ovf_held;
        ovf_r[0] && !wr_ctrl[0] |=> ovf_r[0];
    endproperty
    a_ovf_held: assert property (p_ovf_held)
        else $error("overflow flag dropped without a clear");

    // writing zero to the flag clears it unless a wrap lands too
    property p_ovf_clear;
        wr_ctrl[0] && !pwdata_i[`CTRL_OVF_BIT] && !wrap[0] |=> !ovf_r[0];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow flag not cleared by software");

    // a cleared enable with no cascade run freezes the count
    property p_enable_stop;
        !ctrl_r[0][`CTRL_EN_BIT] && !ord_run_r[0] && !ext_run_r[0]
            && !wr_lo[0] && !wr_hi[0] |=> $stable(count[0]);
    endproperty
    a_enable_stop: assert property (p_enable_stop)
        else $error("stopped counter kept counting");

    property p_casc_start;
        wrap[0] && casc[2] && !wr_ctrl[2] |=> ord_run_r[2] && run[2];
    endproperty
    a_casc_start: assert property (p_casc_start)
        else $error("cascade partner not started");

    property p_casc_halt;
        ord_run_r[2] && !wrap[0] && !ovf_r[0] |=> !ord_run_r[2];
    endproperty
    a_casc_halt: assert property (p_casc_halt)
        else $error("cascade run kept after source clear");

    property p_ext_start;
        wrap[16] && ext[12] && !wr_ctrl[12] |=> ext_run_r[12];
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("extended cascade not started");

    // the cascade flag never lets 16 drive 14 backwards
    property p_no_back_cascade;
        wrap[16] && !wrap[12] && !ord_run_r[14] |=> !ord_run_r[14];
    endproperty
    a_no_back_cascade: assert property (p_no_back_cascade)
        else $error("counter 14 started by counter 16");

    property p_pmi;
        ovf_r[0] && ctrl_r[0][`CTRL_PMI_BIT] |=> performance_monitor_interrupt_o;
    endproperty
    a_pmi: assert property (p_pmi)
        else $error("interrupt request missing");
endmodule

// ### evc_consts.svh
`ifndef EVC_CONSTS_SVH
`define EVC_CONSTS_SVH
// Purpose: constants of the cascaded event counter bank
// Assumes: one core clock, apb register access
// Notes:   one 16-byte slot per counter, ctrl/low/high words

`define NUM_CNT        5'd18
`define CNT_W          40
`define EV_W           4
`define ADDR_W         12
`define SEL_W          3
`define FIRST_NOSEL    16
`define CTRL_EXT_BIT   11
`define CTRL_EN_BIT    12
`define CTRL_SEL_LSB   13
`define CTRL_FORCE_BIT 25
`define CTRL_PMI_BIT   26
`define CTRL_CASC_BIT  30
`define CTRL_OVF_BIT   31
`define CTRL_RST       32'h0000_0000
`define REG_CTRL       2'h0
`define REG_LO         2'h1
`define REG_HI         2'h2
`endif

// ### evc_pkg.sv
// Purpose: shared types of the event counter bank
// Assumes: constants come from the header
// Notes:   bus answer machine has two states
`include "evc_consts.svh"
package evc_pkg;
    typedef logic [31:0]         word_t;
    typedef logic [`EV_W-1:0]    ev_t;
    typedef logic [`CNT_W-1:0]   count_t;
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// ### evc_counter.sv
// Purpose: one wide event counter with wrap detect
// Assumes: writes and counting never share a cycle
// Notes:   a write wins over an increment
`include "evc_consts.svh"
module evc_counter (
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    input  wire logic           run_i,
    input  wire evc_pkg::ev_t   inc_i,
    input  wire logic           force_i,
    input  wire logic           wr_lo_i,
    input  wire logic           wr_hi_i,
    input  wire evc_pkg::word_t wdata_i,
    output evc_pkg::count_t     count_o,
    output logic                wrap_o
);
    import evc_pkg::*;
    count_t             count_r;
    logic [`CNT_W:0]    sum;

    // carry out of the sum marks the wrap
    assign sum     = {1'b0, count_r} + {{(`CNT_W-`EV_W+1){1'b0}}, inc_i};
    assign wrap_o  = run_i && !wr_lo_i && !wr_hi_i
                     && (sum[`CNT_W] || (force_i && inc_i != 4'h0));
    assign count_o = count_r;

    // stopped counter just holds, so reads never disturb it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            count_r <= '0;
        end else if (wr_lo_i) begin
            count_r[31:0] <= wdata_i;
        end else if (wr_hi_i) begin
            count_r[`CNT_W-1:32] <= wdata_i[`CNT_W-33:0];
        end else if (run_i) begin
            count_r <= sum[`CNT_W-1:0];
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_stopped_holds;
        !run_i && !wr_lo_i && !wr_hi_i |=> $stable(count_r);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds)
        else $error("stopped counter changed");

    property p_wrap_low;
        run_i && !wr_lo_i && !wr_hi_i && &count_r && inc_i == 4'h1
            |-> wrap_o ##1 count_r == '0;
    endproperty
    a_wrap_low: assert property (p_wrap_low)
        else $error("counter did not wrap to zero");
endmodule

// ### evc_cascade_route.sv
// Purpose: cascade source map of all eighteen counters
// Assumes: wrap pulses and flags share one clock
// Notes:   a counter has at most one source of each kind
`include "evc_consts.svh"
module evc_cascade_route (
    input  wire logic [`NUM_CNT-1:0] wrap_i,
    input  wire logic [`NUM_CNT-1:0] ovf_i,
    input  wire logic [`NUM_CNT-1:0] casc_i,
    input  wire logic [`NUM_CNT-1:0] ext_i,
    output logic [`NUM_CNT-1:0]      ord_start_o,
    output logic [`NUM_CNT-1:0]      ord_hold_o,
    output logic [`NUM_CNT-1:0]      ext_start_o,
    output logic [`NUM_CNT-1:0]      ext_hold_o
);
    // partner in the other pair of the same block
    function automatic int ord_src(input int i);
        if (i == 16) return 14;
        if (i == 17) return 15;
        return i ^ 2;
    endfunction

    // extended sources exist only in the fourth block
    function automatic int ext_src(input int i);
        case (i)
            12:      return 16;
            15:      return 17;
            16:      return 17;
            17:      return 16;
            default: return -1;
        endcase
    endfunction

    // 16 and 17 never appear as an ordinary source
    for (genvar i = 0; i < 18; i++) begin : g_route
        assign ord_start_o[i] = casc_i[i] && wrap_i[ord_src(i)];
        assign ord_hold_o[i]  = casc_i[i] && ovf_i[ord_src(i)];
        if (ext_src(i) >= 0) begin : g_ext
            assign ext_start_o[i] = ext_i[i] && wrap_i[ext_src(i)];
            assign ext_hold_o[i]  = ext_i[i] && ovf_i[ext_src(i)];
        end else begin : g_noext
            assign ext_start_o[i] = 1'b0;
            assign ext_hold_o[i]  = 1'b0;
        end
    end
endmodule

// ### evc_event_src.sv
// Purpose: pipeline event sources seen by the counter bank
// Assumes: the bench asks for one burst at a time
// Notes:   lines rest at zero, the no-event value, between bursts
module evc_event_src (
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    input  wire logic           go_i,
    input  wire logic [7:0]     len_i,
    input  wire evc_pkg::ev_t   val_i,
    input  wire logic [17:0]    mask_i,
    output evc_pkg::ev_t [17:0] lines_o,
    output logic                busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import evc_pkg::*;
    logic [7:0] left_r;
    logic       act_r;

    // cycles left in the burst; act_r covers the last driven cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            left_r <= 8'h00;
        end else if (go_i) begin
            left_r <= len_i;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
        act_r <= !rst_i && (left_r != 8'h00);
    end

    // one value a cycle on the four lines of each selected counter
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 18; i++) begin
            lines_o[i] <= (!rst_i && left_r != 8'h00 && mask_i[i]) ? val_i : 4'h0;
        end
    end

    assign busy_o = (left_r != 8'h00) | act_r;
endmodule

// ### evc_top_tb.sv
// Purpose: self-checking bench of the cascaded event counter bank
// Assumes: apb master waits for pready, bounded by a timeout
// Notes:   cascade start latency is checked in a small window
`include "evc_consts.svh"
module event_counter_start_stop_cascade_test;
    timeunit 1ns;
    timeprecision 1ps;
    import evc_pkg::*;
    localparam word_t EN = 32'h0000_1000;
    localparam word_t SEL = 32'h0000_2000;
    localparam word_t EXT = 32'h0000_0800;
    localparam word_t FORCE = 32'h0200_0000;
    localparam word_t PERFORMANCE_MONITOR_INTERRUPT = 32'h0400_0000;
    localparam word_t CASC = 32'h4000_0000;
    localparam word_t OVF = 32'h8000_0000;
    // ****************
    // bench signals
    // ****************
    logic         sys_clk = 1'b0;
    logic         rst, psel, penable, pwrite, pready, pslverr, irq, go, busy, rerr;
    logic [11:0]  paddr;
    logic [7:0]   len;
    logic [17:0]  mask;
    word_t        pwdata, prdata, rdat;
    ev_t          val;
    ev_t [17:0]   lines;
    int           n_fail = 0;
    int           samples_checked = 0;

    always #20 sys_clk = ~sys_clk;

    evc_top uut (.sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .event_lines_i(lines),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .performance_monitor_interrupt_o(irq));
    evc_event_src src (.sys_clk_i(sys_clk), .rst_i(rst), .go_i(go), .len_i(len),
        .val_i(val), .mask_i(mask), .lines_o(lines), .busy_o(busy));

    // ****************
    // tasks
    // ****************
    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic bad(input string m);
        n_fail++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task automatic chk_sig(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) bad(m);
    endtask

    // one apb transfer; the request stands until pready is sampled high
    task automatic xfer(input logic w, input int a, input word_t d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a[11:0];
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad("bus answer missing");
            wrap_up;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int i, input int o, input word_t d);
        xfer(1'b1, i * 16 + o, d);
    endtask

    // read a slot word and compare it with a window; exact when lo equals hi
    task automatic chk(input int i, input int o, input word_t lo, input word_t hi, input string m);
        xfer(1'b0, i * 16 + o, 32'h0000_0000);
        samples_checked++;
        if ($isunknown(rdat) || rdat < lo || rdat > hi) bad(m);
    endtask

    task automatic burst(input int l, input ev_t e, input logic [17:0] m);
        @(posedge sys_clk);
        len <= l[7:0];
        val <= e;
        mask <= m;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask

    // wait out a burst, then let the last add land in the count
    task automatic settle;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (busy !== 1'b0 && n < 300);
        if (busy !== 1'b0) begin
            bad("event burst hang");
            wrap_up;
        end
        repeat (2) @(posedge sys_clk);
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        {rst, psel, penable, pwrite, go} = 5'h1f;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        len = 8'h00;
        val = 4'h0;
        mask = 18'h0_0000;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            chk(i, 0, 0, 0, "ctrl not clear after reset");
            chk(i, 4, 0, 0, "count not clear after reset");
        end
        xfer(1'b0, 'h00c, 0);
        chk_sig(rerr, 1'b1, "gap word accepted");
        xfer(1'b1, 'h120, EN);
        chk_sig(rerr, 1'b1, "counter 18 accepted");
        wr(13, 0, EXT);
        chk(13, 0, 0, 0, "reserved extended bit kept");
        wr(0, 0, EXT);
        chk(0, 0, 0, 0, "extended bit outside fourth block");
        // start, read while running, stop
        wr(0, 0, EN | SEL);
        burst(40, 4'h3, 18'h0_0001);
        chk(0, 4, 3, 117, "running read");
        settle;
        chk(0, 4, 120, 120, "enabled count");
        wr(0, 0, SEL);
        burst(10, 4'h5, 18'h0_0001);
        settle;
        chk(0, 4, 120, 120, "count after stop");
        // wrap from the top of the count
        wr(0, 4, 32'hffff_fffe);
        wr(0, 8, 32'h0000_00ff);
        wr(0, 0, EN | SEL | PERFORMANCE_MONITOR_INTERRUPT);
        burst(2, 4'h3, 18'h0_0001);
        settle;
        chk(0, 4, 4, 4, "wrap low word");
        chk(0, 8, 0, 0, "wrap high word");
        chk(0, 0, OVF | EN | SEL | PERFORMANCE_MONITOR_INTERRUPT, OVF | EN | SEL | PERFORMANCE_MONITOR_INTERRUPT, "overflow flag");
        chk_sig(irq, 1'b1, "interrupt request");
        wr(0, 0, EN | SEL | PERFORMANCE_MONITOR_INTERRUPT);
        chk(0, 0, EN | SEL | PERFORMANCE_MONITOR_INTERRUPT, EN | SEL | PERFORMANCE_MONITOR_INTERRUPT, "overflow clear");
        chk_sig(irq, 1'b0, "interrupt after clear");
        wr(0, 0, 0);
        // ordinary cascade 0 into 2; 1 shares the pair and must stay idle
        wr(0, 4, 32'hffff_fffd);
        wr(0, 8, 32'h0000_00ff);
        wr(2, 0, CASC | SEL);
        wr(1, 0, CASC | SEL);
        wr(0, 0, EN | SEL);
        burst(10, 4'h1, 18'h0_000f);
        settle;
        chk(2, 4, 6, 8, "cascade start");
        chk(1, 4, 0, 0, "cascade inside a pair");
        wr(0, 0, EN | SEL);
        burst(5, 4'h1, 18'h0_0004);
        settle;
        chk(2, 4, 7, 7, "cascade run after source clear");
        // extended cascade 16 into 12; 14 must not follow 16
        wr(16, 4, 32'hffff_fffd);
        wr(16, 8, 32'h0000_00ff);
        wr(14, 0, CASC | SEL);
        wr(12, 0, EXT | SEL);
        wr(16, 0, EN);
        burst(10, 4'h1, 18'h1_5000);
        settle;
        chk(12, 0, EXT | SEL, EXT | SEL, "extended bit readback");
        chk(12, 4, 6, 8, "extended cascade start");
        chk(14, 4, 0, 0, "ordinary cascade from 16");
        chk(16, 4, 7, 7, "counter 16 without select");
        // forced overflow flags every add while the count stays exact
        wr(4, 0, EN | SEL | FORCE);
        burst(2, 4'h1, 18'h0_0010);
        settle;
        chk(4, 4, 2, 2, "forced overflow count");
        chk(4, 0, OVF | FORCE | EN | SEL, OVF | FORCE | EN | SEL, "forced flag");
        wrap_up;
    end

    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad("run too long");
        wrap_up;
    end
endmodule
